// ==== hdl/tsie_pkg.sv ====
// Constants shared by the stage interrupt enable and status block.
`default_nettype none
package tsie_pkg;
    // Register access port geometry.
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned STAGES = 12;

    // Register offsets.
    localparam logic [9:0] STAGE_DONE_IRQ_ENABLE_OFS = 10'h007;
    localparam logic [9:0] LOW_THRESHOLD_HIT_STATUS_OFS = 10'h008;
    localparam logic [9:0] DONE_PENDING_STATUS_OFS = 10'h00A;

    // Field positions inside the completion-enable register.
    localparam int unsigned STEP0_DONE_IRQ_EN_POS = 0;
    localparam int unsigned STEP11_DONE_IRQ_EN_POS = 11;
    localparam int unsigned GPIO_IRQ_EN_POS = 12;

    // Field positions inside the low-limit status register.
    localparam int unsigned STEP0_LOW_HIT_POS = 0;
    localparam int unsigned STEP11_LOW_HIT_POS = 11;

    // Field position of the input-change pending bit in the pending register.
    localparam int unsigned GPIO_PEND_POS = 12;

    // Reset values.
    localparam logic [15:0] STAGE_DONE_IRQ_ENABLE_RST = 16'h0000;
    localparam logic [15:0] LOW_THRESHOLD_HIT_STATUS_RST = 16'h0000;
    localparam logic [15:0] RDATA_RST = 16'h0000;

    // Writable bits of the completion-enable register; bits 15:13 hold zero.
    localparam logic [15:0] STAGE_DONE_IRQ_ENABLE_MASK = 16'h1FFF;

    // Synchroniser depth for the general-purpose input pin.
    localparam int unsigned SYNC_STAGES = 2;
endpackage
`default_nettype wire

// ==== hdl/tsie_sync.sv ====
// Two-flop level synchroniser for an asynchronous input pin.
`default_nettype none
module tsie_sync (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic async_i,
    output logic sync_o
);
    logic meta_r;
    logic hold_r;

    // The first flop feeds only the second, so metastability settles before use.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_r <= 1'b0;
            hold_r <= 1'b0;
        end else begin
            meta_r <= async_i;
            hold_r <= meta_r;
        end
    end

    assign sync_o = hold_r;
endmodule
`default_nettype wire

// ==== hdl/tsie_top.sv ====
// Stage completion, low-threshold and input-change interrupt logic with its registers.
`default_nettype none
// Operation
// - Enabled stage completion asserts interrupt output low.
// - Disabled completion ignored; enables reset to zero.
// - Input-change enable gates pin level changes.
// - Low crossing sets that stage's status bit.
// - Low status read-only, resets to zero.
// - Low status read clears bits no longer exceeded.
// - Low-threshold enable needed before low interrupt.
module tsie_top (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [9:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    input wire logic [11:0] step_done_i,
    input wire logic [11:0] step_low_exceed_i,
    input wire logic [11:0] step_low_irq_en_i,
    input wire logic gpio_pin_i,
    output logic irq_n_o
);
    logic [15:0] stage_done_irq_enable_r;
    logic [15:0] stage_done_irq_enable_nxt;
    logic [11:0] low_hit_r;
    logic [11:0] low_hit_nxt;
    logic [11:0] done_pend_r;
    logic [11:0] done_pend_nxt;
    logic gpio_pend_r;
    logic gpio_pend_nxt;
    logic gpio_sync;
    logic gpio_last_r;
    logic gpio_change;
    logic [15:0] rdata_nxt;
    logic irq_any;
    logic irq_n_r;
    logic wr_enable;
    logic rd_low;
    logic rd_pend;

    // Address decode for the internal register port.
    assign wr_enable = reg_wr_i && (reg_addr_i == tsie_pkg::STAGE_DONE_IRQ_ENABLE_OFS);
    assign rd_low = reg_rd_i && (reg_addr_i == tsie_pkg::LOW_THRESHOLD_HIT_STATUS_OFS);
    assign rd_pend = reg_rd_i && (reg_addr_i == tsie_pkg::DONE_PENDING_STATUS_OFS);

    // The pin is asynchronous to the conversion clock, so it is synchronised first.
    tsie_sync u_gpio_sync (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .async_i(gpio_pin_i),
        .sync_o(gpio_sync)
    );

    // Previous synchronised level, used to see a change in either direction.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gpio_last_r <= 1'b0;
        end else begin
            gpio_last_r <= gpio_sync;
        end
    end

    // A pin that is high at reset release shows as one change; software may clear it.
    assign gpio_change = gpio_sync ^ gpio_last_r;

    // Unused upper bits are masked so that a careless write cannot set them.
    always_comb begin
        stage_done_irq_enable_nxt = stage_done_irq_enable_r;
        if (wr_enable) begin
            stage_done_irq_enable_nxt = reg_wdata_i & tsie_pkg::STAGE_DONE_IRQ_ENABLE_MASK;
        end
    end

    // Completion-enable register, cleared by reset.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stage_done_irq_enable_r <= tsie_pkg::STAGE_DONE_IRQ_ENABLE_RST;
        end else begin
            stage_done_irq_enable_r <= stage_done_irq_enable_nxt;
        end
    end

    // Low status: a read drops bits whose stage is no longer below its limit.
    // The current crossing is ORed in last, so a set in the read cycle wins.
    always_comb begin
        low_hit_nxt = low_hit_r;
        if (rd_low) begin
            low_hit_nxt = step_low_exceed_i;
        end
        low_hit_nxt = low_hit_nxt | step_low_exceed_i;
    end

    // Low status register has no write path at all.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            low_hit_r <= tsie_pkg::LOW_THRESHOLD_HIT_STATUS_RST[11:0];
        end else begin
            low_hit_r <= low_hit_nxt;
        end
    end

    // Completion and input-change pendings clear on read, but a new event wins.
    always_comb begin
        done_pend_nxt = done_pend_r;
        gpio_pend_nxt = gpio_pend_r;
        if (rd_pend) begin
            done_pend_nxt = '0;
            gpio_pend_nxt = 1'b0;
        end
        done_pend_nxt = done_pend_nxt |
            (step_done_i & stage_done_irq_enable_r[tsie_pkg::STEP11_DONE_IRQ_EN_POS:tsie_pkg::STEP0_DONE_IRQ_EN_POS]);
        if (gpio_change && stage_done_irq_enable_r[tsie_pkg::GPIO_IRQ_EN_POS]) begin
            gpio_pend_nxt = 1'b1;
        end
    end

    // Sticky pending flags for completion and input change.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_pend_r <= '0;
            gpio_pend_r <= 1'b0;
        end else begin
            done_pend_r <= done_pend_nxt;
            gpio_pend_r <= gpio_pend_nxt;
        end
    end

    // Low hits reach the pin only through their own per-stage enable.
    assign irq_any = (|done_pend_r) | gpio_pend_r | (|(low_hit_r & step_low_irq_en_i));

    // Registered active-low pin so it never glitches between sources.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_n_r <= 1'b1;
        end else begin
            irq_n_r <= ~irq_any;
        end
    end

    assign irq_n_o = irq_n_r;

    // Read mux; unmapped addresses answer zero, unused bits read zero.
    always_comb begin
        rdata_nxt = tsie_pkg::RDATA_RST;
        if (reg_rd_i) begin
            case (reg_addr_i)
                tsie_pkg::STAGE_DONE_IRQ_ENABLE_OFS: rdata_nxt = stage_done_irq_enable_r;
                tsie_pkg::LOW_THRESHOLD_HIT_STATUS_OFS: rdata_nxt = {4'h0, low_hit_r};
                tsie_pkg::DONE_PENDING_STATUS_OFS: rdata_nxt = {3'h0, gpio_pend_r, done_pend_r};
                default: rdata_nxt = tsie_pkg::RDATA_RST;
            endcase
        end
    end

    // Read data is held until the next read so the serial shifter can take it at leisure.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= tsie_pkg::RDATA_RST;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== sim/tsie_host.sv ====
// Host model that drives the register port.
`default_nettype none
module tsie_host (
    input wire logic clock_i,
    output logic [9:0] addr_o = 10'h000,
    output logic wr_o = 1'b0,
    output logic [15:0] wdata_o = 16'h0000,
    output logic rd_o = 1'b0
);
    // One access whose strobe stays up n edges; released strobes go low, address and data lines show inverted values.
    task automatic access(input logic w, input logic [9:0] a, input logic [15:0] d, input int n);
        @(posedge clock_i);
        addr_o <= a;
        wr_o <= w;
        rd_o <= !w;
        wdata_o <= d & (a == 10'h008 ? 16'h0FFF : 16'h1FFF);
        repeat (n) @(posedge clock_i);
        addr_o <= ~a;
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        wdata_o <= ~d;
    endtask
endmodule
`default_nettype wire

// ==== sim/tsie_top_assertions.sv ====
// Interrupt block checker.
`default_nettype none
module tsie_chk (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic gpio_pin_i,
    input wire logic irq_n_o,
    input wire logic [9:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic [11:0] step_done_i,
    input wire logic [11:0] step_low_exceed_i,
    input wire logic [11:0] step_low_irq_en_i
);
    logic [12:0] en_r;
    wire logic rd8 = reg_rd_i && reg_addr_i == 10'h008;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // Own copy of the enables.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) en_r <= 13'h0000;
        else if (reg_wr_i && reg_addr_i == 10'h007) en_r <= reg_wdata_i[12:0];
    end
    // Pin and read-data timing.
    chk_done_irq: assert property (|(step_done_i & en_r[11:0]) |-> ##2 !irq_n_o) else $error("irq");
    chk_en_read: assert property (reg_rd_i && reg_addr_i == 10'h007 |=> reg_rdata_o == {3'h0, en_r})
        else $error("en");
    chk_gpio_irq: assert property ($changed(gpio_pin_i) && en_r[12] |-> ##[2:6] !irq_n_o) else $error("irq");
    chk_low_seen: assert property (rd8 |=> &(reg_rdata_o[11:0] | ~$past(step_low_exceed_i, 2)))
        else $error("low");
    chk_low_upper: assert property (rd8 |=> reg_rdata_o[15:12] == 4'h0) else $error("top");
    chk_low_clear: assert property (rd8 ##1 rd8 |=> reg_rdata_o[11:0] == $past(step_low_exceed_i, 2))
        else $error("clr");
    chk_low_irq: assert property (|(step_low_exceed_i & step_low_irq_en_i) |-> ##2 !irq_n_o) else $error("irq");
    chk_irq_release: assert property ($rose(irq_n_o) |-> $past(reg_rd_i, 2)) else $error("rise");
    cover property ($fell(irq_n_o));
    cover property (rd8 ##1 rd8);
    cover property ($changed(gpio_pin_i) && en_r[12]);
endmodule
bind tsie_top tsie_chk i_chk (.clock_i, .rstn_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
    .step_done_i, .step_low_exceed_i, .step_low_irq_en_i, .gpio_pin_i, .irq_n_o);
`default_nettype wire

// ==== sim/test_tsie_top.sv ====
// Bench for the stage interrupt block.
`default_nettype none
module test_tsie_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_i = 1'b0, rstn_i = 1'b0, reg_wr_i, reg_rd_i, gpio_pin_i = 1'b0, irq_n_o;
    logic [9:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o;
    logic [11:0] step_done_i = 12'h000, step_low_exceed_i = 12'h000, step_low_irq_en_i = 12'h004;
    int errors = 0, cmp_count = 0;
    // Rows: enables, completion pulses, pending bits expected.
    logic [35:0] tab [3] = '{36'hFFF_801_801, 36'h000_FFF_000, 36'h5A5_8FF_0A5};
    always #12.5 clock_i = ~clock_i;
    tsie_top i_dut (.clock_i, .rstn_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
        .step_done_i, .step_low_exceed_i, .step_low_irq_en_i, .gpio_pin_i, .irq_n_o);
    tsie_host i_host (.clock_i, .addr_o(reg_addr_i), .wr_o(reg_wr_i), .wdata_o(reg_wdata_i), .rd_o(reg_rd_i));
    task automatic chk(input logic [15:0] s, input logic [15:0] e, input string n);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    // The pin settles two edges after its cause.
    task automatic irq(input logic e);
        repeat (2) @(posedge clock_i);
        #1 chk(16'(irq_n_o), 16'(e), "irq_n");
    endtask
    task automatic rd(input logic [9:0] a, input int n, input logic [15:0] e);
        i_host.access(1'b0, a, 16'h0000, n);
        #1 chk(reg_rdata_o, e, "rdata");
    endtask
    task automatic test_done();
        if (errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Table first, then thresholds, the input pin and a reset in mid-run.
    initial begin
        repeat (20) @(posedge clock_i);
        rstn_i <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            i_host.access(1'b1, 10'h007, {4'h0, tab[i][35:24]}, 1);
            @(posedge clock_i);
            step_done_i <= tab[i][23:12];
            @(posedge clock_i);
            step_done_i <= 12'h000;
            irq(tab[i][11:0] == 12'h000);
            rd(10'h00A, 1, {4'h0, tab[i][11:0]});
            irq(1'b1);
        end
        @(posedge clock_i);
        step_low_exceed_i <= 12'h014;
        irq(1'b0);
        @(posedge clock_i);
        step_low_exceed_i <= 12'h010;
        rd(10'h008, 2, 16'h0010);
        irq(1'b1);
        i_host.access(1'b1, 10'h008, 16'hFFFF, 1);
        rd(10'h008, 1, 16'h0010);
        i_host.access(1'b1, 10'h007, 16'h1000, 1);
        @(posedge clock_i);
        gpio_pin_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        irq(1'b0);
        rd(10'h00A, 1, 16'h1000);
        @(posedge clock_i);
        rstn_i <= 1'b0;
        #1 chk(reg_rdata_o, 16'h0000, "rdata");
        chk(16'(irq_n_o), 16'h0001, "irq_n_reset");
        @(posedge clock_i);
        rstn_i <= 1'b1;
        rd(10'h007, 1, 16'h0000);
        rd(10'h00A, 1, 16'h0000);
        @(posedge clock_i);
        gpio_pin_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        irq(1'b1);
        test_done();
    end
endmodule
`default_nettype wire
